/* design/sram_ctrl.sv */
// Host controller driving an asynchronous 32K x 8 static memory
`include "sram_ctrl_defines.svh"
`timescale 1ns/1ps
module sram_ctrl
    import sram_ctrl_pkg::*;
#(
    parameter int AW = `ADDR_W,
    parameter int DW = `DATA_W
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // User request
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    output logic               req_ready,
    output logic               rsp_valid,
    output logic [DW-1:0]      rsp_rdata,
    // Retention control
    input  wire logic          retain_req,
    output logic               retain_ok,
    // Memory pins
    output logic [AW-1:0]      word_address,
    output logic               chip_sel_n,
    output logic               out_en_n,
    output logic               write_en_n,
    output logic [DW-1:0]      data_bus_o,
    output logic               data_bus_oe,
    input  wire logic [DW-1:0] data_bus_i
);
    import sram_ctrl_pkg::*;

    localparam logic [`CNT_W-1:0] PULSE_CYC = `CNT_W'(`WRITE_PULSE_CYC);
    localparam logic [`CNT_W-1:0] SETUP_CYC = `CNT_W'(`DATA_SETUP_CYC);
    localparam logic [`CNT_W-1:0] ACC_CYC   = `CNT_W'(`ACCESS_CYC + 2);
    localparam logic [`CNT_W-1:0] REL_CYC   = `CNT_W'(`RELEASE_CYC);
    localparam logic [`CNT_W-1:0] REC_CYC   = `CNT_W'(`RECOVERY_CYC);

    ////////////////////////////////////////////////////////////////////////
    // State and pin registers
    ctrl_state_e       state_r, state_nxt;
    logic [`CNT_W-1:0] cnt_r, cnt_nxt;
    logic [DW-1:0]     rd_sync;

    // Read data pass two flops before use; costs two cycles of latency
    // but keeps a settling bus away from any logic
    sync2 #(.W(DW)) u_rd_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (data_bus_i),
        .q     (rd_sync)
    );

    wire cnt_done   = (cnt_r == '0);
    // Requests count only while ready shows, so none is taken straight
    // out of reset; retention wins over a request in the same cycle
    wire take_write = req_valid && req_ready && req_write && !retain_req;
    wire take_read  = req_valid && req_ready && !req_write && !retain_req;
    // Any state change reloads the counter for the state entered
    wire cnt_load   = (state_r != state_nxt);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (retain_req)
                    state_nxt = ST_RETAIN;
                else if (take_write)
                    state_nxt = ST_W_SETUP;
                else if (take_read)
                    state_nxt = ST_R_SETUP;
            end
            // One cycle of address and data setup before strobes fall
            ST_W_SETUP: state_nxt = ST_W_PULSE;
            ST_W_PULSE: begin
                if (cnt_done)
                    state_nxt = ST_W_END;
            end
            ST_W_END:   state_nxt = ST_IDLE;
            // Address settles a cycle before chip select falls
            ST_R_SETUP: state_nxt = ST_R_WAIT;
            ST_R_WAIT: begin
                if (cnt_done)
                    state_nxt = ST_R_END;
            end
            ST_R_END:   state_nxt = ST_IDLE;
            ST_RETAIN: begin
                // Stay until the request drops and recovery has run
                if (!retain_req && cnt_done)
                    state_nxt = ST_IDLE;
            end
            default:    state_nxt = ST_IDLE;
        endcase
    end

    // Pulse length covers both the pulse minimum and data setup
    wire [`CNT_W-1:0] w_len = (PULSE_CYC > SETUP_CYC) ? PULSE_CYC : SETUP_CYC;

    always_comb begin
        cnt_nxt = cnt_done ? cnt_r : cnt_r - `CNT_W'(1);
        if (cnt_load) begin
            case (state_nxt)
                ST_W_PULSE: cnt_nxt = w_len - `CNT_W'(1);
                ST_R_WAIT:  cnt_nxt = ACC_CYC - `CNT_W'(1);
                ST_RETAIN:  cnt_nxt = REC_CYC;
                default:    cnt_nxt = '0;
            endcase
        end else if (state_r == ST_RETAIN && retain_req) begin
            // Reload while held, so recovery counts from the release
            cnt_nxt = REC_CYC;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin values for the next cycle
    // Phase decode of a state, shared by the strobe and bus logic
    function automatic logic is_write_state(input ctrl_state_e s);
        return (s == ST_W_SETUP) || (s == ST_W_PULSE) || (s == ST_W_END);
    endfunction

    function automatic logic is_read_state(input ctrl_state_e s);
        return (s == ST_R_SETUP) || (s == ST_R_WAIT) || (s == ST_R_END);
    endfunction

    // States in which the memory is selected
    function automatic logic is_select_state(input ctrl_state_e s);
        return (s == ST_W_PULSE) || (s == ST_R_WAIT) || (s == ST_R_END);
    endfunction

    wire in_write  = is_write_state(state_nxt);
    wire in_read   = is_read_state(state_nxt);
    // Chip select and write enable assert only once address and data have settled; output enable falls with the address
    wire cs_nxt_n  = !is_select_state(state_nxt);
    wire we_nxt_n  = (state_nxt != ST_W_PULSE);
    wire oe_nxt_n  = !in_read;
    wire load_req  = (state_r == ST_IDLE) && (take_write || take_read)
                     && !retain_req;
    // Answer strobe: the last read state has seen data through two flops
    wire rsp_nxt   = (state_r == ST_R_END);
    wire ready_nxt = (state_nxt == ST_IDLE) && !retain_req;
    wire keep_nxt  = (state_nxt == ST_RETAIN) && retain_req;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory strobes, all idle high out of reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_sel_n <= 1'b1;
            write_en_n <= 1'b1;
            out_en_n   <= 1'b1;
        end else begin
            // Chip select and write enable rise together to end a write
            chip_sel_n <= cs_nxt_n;
            write_en_n <= we_nxt_n;
            out_en_n   <= oe_nxt_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and write data, held from one take to the next
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word_address <= '0;
            data_bus_o   <= '0;
            data_bus_oe  <= 1'b0;
        end else begin
            // Data driven over the whole write, released after the edge
            data_bus_oe <= in_write;
            if (load_req) begin
                word_address <= req_addr;
                data_bus_o   <= req_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // User handshake and read answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            retain_ok <= 1'b0;
        end else begin
            req_ready <= ready_nxt;
            rsp_valid <= rsp_nxt;
            retain_ok <= keep_nxt;
            // Read data stands until the next read answer replaces it
            if (rsp_nxt)
                rsp_rdata <= rd_sync;
        end
    end
endmodule

/* design/sram_ctrl_defines.svh */
// Timing and geometry constants for the static memory controller
`ifndef SRAM_CTRL_DEFINES_SVH
`define SRAM_CTRL_DEFINES_SVH

`define CLK_PERIOD_NS        100
`define ADDR_W               15
`define DATA_W               8
`define WORD_COUNT           32768
// Slow grade figures, the safer of the two grades
`define WRITE_CYCLE_MIN_NS   45
`define WRITE_PULSE_MIN_NS   25
`define DATA_SETUP_MIN_NS    20
`define READ_CYCLE_MIN_NS    45
`define ACCESS_MAX_NS        45
`define BUS_RELEASE_MAX_NS   20
// Least times rounded up to whole cycles, never below one
`define NS2CYC(t)            ((((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) \
                              < 1 ? 1 : (((t) + `CLK_PERIOD_NS - 1) \
                              / `CLK_PERIOD_NS))
`define WRITE_PULSE_CYC      `NS2CYC(`WRITE_PULSE_MIN_NS)
`define DATA_SETUP_CYC       `NS2CYC(`DATA_SETUP_MIN_NS)
`define ACCESS_CYC           `NS2CYC(`ACCESS_MAX_NS)
`define RELEASE_CYC          `NS2CYC(`BUS_RELEASE_MAX_NS)
`define RECOVERY_CYC         `NS2CYC(`READ_CYCLE_MIN_NS)
`define CNT_W                4

`endif

/* design/sram_ctrl_pkg.sv */
// Types shared by the static memory controller
package sram_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_W_SETUP = 3'b001,
        ST_W_PULSE = 3'b010,
        ST_W_END   = 3'b011,
        ST_R_SETUP = 3'b100,
        ST_R_WAIT  = 3'b101,
        ST_R_END   = 3'b110,
        ST_RETAIN  = 3'b111
    } ctrl_state_e;
endpackage

/* design/sync2.sv */
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

/* verif/sram_ctrl_monitor.sv */
// Pin and handshake checker for the memory controller
`timescale 1ns/1ps
module sram_ctrl_monitor #(parameter int AW = 15, parameter int DW = 8) (
    // Control and status
    input wire logic clk, rst_n, req_valid, req_write, req_ready,
    input wire logic rsp_valid, retain_ok, chip_sel_n, out_en_n,
    input wire logic write_en_n, data_bus_oe,
    // Buses
    input wire logic [AW-1:0] word_address,
    input wire logic [DW-1:0] data_bus_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire take_w = req_valid && req_ready;
    AST_PULSE: assert property ($fell(write_en_n) |=> $rose(write_en_n))
        else $error("write pulse length");
    AST_END: assert property ($rose(write_en_n) |-> $rose(chip_sel_n))
        else $error("write end split");
    AST_HOLD: assert property ($rose(write_en_n) |-> data_bus_oe
        && $stable(data_bus_o) && $stable(word_address)) else $error("hold");
    AST_WDATA: assert property (!write_en_n |-> data_bus_oe
        && $stable(data_bus_o)) else $error("write data moved");
    AST_RD_WE: assert property (!out_en_n |-> write_en_n)
        else $error("write enable low in read");
    AST_ADDR: assert property (!chip_sel_n |-> $stable(word_address))
        else $error("address moved while selected");
    AST_RD_LAT: assert property (take_w && !req_write |-> ##6 rsp_valid)
        else $error("read answer late");
    AST_WR_LAT: assert property (take_w && req_write
        |=> !req_ready [*3] ##1 req_ready) else $error("write length");
    AST_RETAIN: assert property (retain_ok |-> chip_sel_n && write_en_n)
        else $error("selected in retention");
    cover property (take_w && req_write);
    cover property (rsp_valid);
    cover property (retain_ok);
endmodule
bind sram_ctrl sram_ctrl_monitor #(.AW(AW), .DW(DW)) mon_u (.clk(clk),
    .rst_n(rst_n), .req_valid(req_valid), .req_write(req_write),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .retain_ok(retain_ok),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
    .data_bus_oe(data_bus_oe), .word_address(word_address),
    .data_bus_o(data_bus_o));

/* verif/sram_model.sv */
// Behavioural 32K x 8 static memory at the controller pins
`timescale 1ns/1ps
module sram_model #(parameter int ACC_NS = 45) (
    input wire logic [14:0] word_address,
    input wire logic chip_sel_n, out_en_n, write_en_n, data_bus_oe,
    input wire logic [7:0] data_bus_o,
    output logic [7:0] data_bus_i
);
    logic [7:0] mem [0:32767];
    logic [7:0] rd_w;
    logic [7:0] flt_r = 8'h5A;
    wire drive_w = !chip_sel_n && !out_en_n && write_en_n;
    // Released bus must not look like held data
    always #100 flt_r = ~flt_r;
    always @* if (!chip_sel_n && !write_en_n)
        mem[word_address] = data_bus_o;
    assign #(ACC_NS) rd_w = mem[word_address];
    assign data_bus_i = data_bus_oe ? data_bus_o : drive_w ? rd_w : flt_r;
endmodule

/* verif/test_sram_ctrl.sv */
// Self-checking bench for the static memory controller
`timescale 1ns/1ps
module test_sram_ctrl;
    logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0, retain_req = 0;
    logic [14:0] req_addr = 0, word_address;
    logic [7:0] req_wdata = 0, rsp_rdata, data_bus_o, data_bus_i;
    logic req_ready, rsp_valid, retain_ok, chip_sel_n, out_en_n;
    logic write_en_n, data_bus_oe;
    int err_total = 0, checks = 0;
    logic [7:0] ref_m [int];
    sram_ctrl dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .retain_req(retain_req), .retain_ok(retain_ok),
        .word_address(word_address), .chip_sel_n(chip_sel_n),
        .out_en_n(out_en_n), .write_en_n(write_en_n),
        .data_bus_o(data_bus_o), .data_bus_oe(data_bus_oe),
        .data_bus_i(data_bus_i));
    sram_model #(.ACC_NS(45)) mem_u (.word_address(word_address),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .data_bus_oe(data_bus_oe),
        .data_bus_o(data_bus_o), .data_bus_i(data_bus_i));
    initial forever #50 clk = ~clk;
    task chk(input string nm, input logic [14:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    function logic [7:0] exp_rd(input logic [14:0] a);
        return ref_m.exists(a) ? ref_m[a] : 8'h00;
    endfunction
    task final_report;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Entered at a falling edge; n is edges from take to completion
    task op(input logic w, input logic [14:0] a, input logic [7:0] d,
            output int n);
        for (n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        for (n = 1; n < 40; n++) begin
            @(negedge clk);
            if (w ? req_ready === 1'b1 : rsp_valid === 1'b1) break;
        end
    endtask
    initial begin
        logic [14:0] a;
        logic [7:0] d;
        int n;
        void'($urandom(73));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        // First two are the address and data extremes
        for (int i = 0; i < 24; i++) begin
            a = i < 2 ? {15{i[0]}} : 15'($urandom);
            d = i < 2 ? {8{~i[0]}} : 8'($urandom);
            op(1'b1, a, d, n);
            chk("wr_len", 15'(n), 15'd4);
            ref_m[a] = d;
            op(1'b0, a, 8'h00, n);
            chk("rd_len", 15'(n), 15'd6);
            chk("rd_data", 15'(rsp_rdata), 15'(exp_rd(a)));
        end
        @(posedge clk);
        retain_req <= 1'b1;
        repeat (3) @(negedge clk);
        chk("retain", {13'd0, retain_ok, chip_sel_n}, 15'd3);
        chk("no_take", 15'(req_ready), 15'd0);
        @(posedge clk);
        retain_req <= 1'b0;
        @(negedge clk);
        op(1'b0, a, 8'h00, n);
        chk("kept", 15'(rsp_rdata), 15'(exp_rd(a)));
        final_report;
    end
    initial begin
        #(100 * 3000);
        err_total++;
        final_report;
    end
endmodule
